// File: core/abo_buffer.sv
// circular acquisition buffer with overrun handling, trigger tracking and time tags
`timescale 1ns/100ps
`include "abo_consts.svh"

// Notes on behaviour
// - second start or stop in one acquisition sets trigger overrun, nothing else
// - error source query returns the error source register including trigger overrun
// - full buffer keeps accepting scans, overwriting oldest data
// - overrun is flagged in the status summary byte, readable by query
// - single block overrun drops whole pre-trigger; read resumes at trigger point
// - single block without unread pre-trigger drops only the oldest scan
// - scan read during its own overwrite may carry erroneous contents
// - with several blocks stored, overrun drops the oldest whole block
// - block under read is dropped; read pointer jumps to next block start
// - overrun status bit clears only on empty buffer or buffer reset
// - millisecond clock, settable, tags every scan in the buffer
// - open or range error sets error status and stores signed sentinel
// - range error on converter full scale or linearization limit exceeded
// - error checking only on activated channels
// - external edge trigger processed about 610.95 us after detection
module abo_buffer #(
    parameter int DEPTH = 16,
    parameter int MS_CYCLES = `ABO_RTC_RES_MS * `ABO_NS_PER_MS / `ABO_CLK_NS,
    parameter int TRIG_LAT_CYCLES = `ABO_TRIG_LAT_CUS * `ABO_NS_PER_CUS / `ABO_CLK_NS
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_buf_reset,
    input wire logic i_acq_arm,
    input wire logic i_acq_end,
    input wire logic i_ext_trig,
    input wire logic i_trig_falling,
    input wire logic i_soft_trig,
    input wire logic i_trig_stop,
    input wire logic i_scan_valid,
    input wire abo_pkg::abo_scan_s i_scan,
    input wire logic i_rd_req,
    input wire logic i_err_query,
    input wire logic i_status_byte_query_cmd,
    input wire logic i_rtc_set,
    input wire logic [31:0] i_rtc_ms,
    output logic o_rd_valid,
    output abo_pkg::abo_entry_s o_rd_data,
    output logic o_err_reply_valid,
    output logic [7:0] o_err_reply,
    output logic o_stb_reply_valid,
    output logic [7:0] o_stb_reply,
    output logic [7:0] o_status_summary_byte,
    output logic [7:0] o_error_source_reg,
    output logic o_overrun_status_bit,
    output logic [$clog2(DEPTH):0] o_scan_count,
    output logic [31:0] o_rtc_now_ms
);
    localparam int AW = $clog2(DEPTH);
    localparam int MW = $clog2(MS_CYCLES);
    localparam int LW = $clog2(TRIG_LAT_CYCLES);

    typedef struct packed {
        abo_pkg::abo_entry_s [DEPTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
        logic [AW:0] nblk;
        abo_pkg::abo_acq_e acq;
        logic first_pend;
        logic trig_pend;
        logic start_seen;
        logic stop_seen;
        logic [2:0] sync;
        logic lat_busy;
        logic [LW-1:0] lat_cnt;
        logic [MW-1:0] ms_div;
        logic [31:0] rtc;
        logic [7:0] esr;
        logic ovr;
        logic [7:0] err_reply;
        logic err_rv;
        logic [7:0] stb_reply;
        logic stb_rv;
        abo_pkg::abo_entry_s rd_data;
        logic rd_valid;
    } abo_state_s;

    abo_state_s q;
    abo_state_s d;
    logic [7:0] stb_now;

    always_comb begin
        stb_now = 8'h00;
        stb_now[`ABO_STB_OVERRUN] = q.ovr;
        stb_now[`ABO_STB_SCAN_AVAIL] = (q.cnt != '0);
    end

    always_comb begin
        logic [7:0] esr_set;
        logic start_evt;
        logic edge_seen;
        logic do_wr;
        logic found_b;
        logic found_t;
        logic [AW-1:0] bidx;
        logic [AW-1:0] tidx;
        logic [AW-1:0] idx;
        logic [AW-1:0] new_rd;
        logic [AW-1:0] drop;
        abo_pkg::abo_entry_s e;
        esr_set = 8'h00;
        start_evt = i_soft_trig;
        edge_seen = 1'b0;
        found_b = 1'b0;
        found_t = 1'b0;
        bidx = '0;
        tidx = '0;
        idx = '0;
        new_rd = '0;
        drop = '0;
        e = '0;
        do_wr = i_scan_valid && (q.acq != abo_pkg::ACQ_IDLE);
        d = q;
        d.err_rv = 1'b0;
        d.stb_rv = 1'b0;
        d.rd_valid = 1'b0;
        // real-time clock, millisecond steps
        if (i_rtc_set) begin
            d.rtc = i_rtc_ms;
            d.ms_div = '0;
        end else if (q.ms_div == MW'(MS_CYCLES - 1)) begin
            d.ms_div = '0;
            d.rtc = q.rtc + 32'h1;
        end else begin
            d.ms_div = q.ms_div + MW'(1);
        end
        // pin synchroniser; only the second and third stages feed the edge detector
        d.sync = {q.sync[1:0], i_ext_trig};
        edge_seen = i_trig_falling ? (q.sync[2] & ~q.sync[1]) : (q.sync[1] & ~q.sync[2]);
        if (q.lat_busy) begin
            if (q.lat_cnt == LW'(TRIG_LAT_CYCLES - 1)) begin
                d.lat_busy = 1'b0;
                start_evt = 1'b1;
            end else begin
                d.lat_cnt = q.lat_cnt + LW'(1);
            end
        end
        if (edge_seen && q.acq != abo_pkg::ACQ_IDLE) begin
            if (q.lat_busy) begin
                esr_set[`ABO_ESR_TRIG_OVR] = 1'b1;
            end else begin
                d.lat_busy = 1'b1;
                d.lat_cnt = '0;
            end
        end
        // start and stop events; repeats only raise the flag
        if (start_evt && q.acq != abo_pkg::ACQ_IDLE) begin
            if (q.start_seen) begin
                esr_set[`ABO_ESR_TRIG_OVR] = 1'b1;
            end else begin
                d.start_seen = 1'b1;
                d.acq = abo_pkg::ACQ_POST;
                d.trig_pend = 1'b1;
            end
        end
        if (i_trig_stop && q.acq != abo_pkg::ACQ_IDLE) begin
            if (q.stop_seen) begin
                esr_set[`ABO_ESR_TRIG_OVR] = 1'b1;
            end else begin
                d.stop_seen = 1'b1;
            end
        end
        // scan entry with sentinel substitution
        e.value = i_scan.value;
        e.ts_ms = q.rtc;
        e.trig = q.trig_pend;
        if (i_scan.ch_active && (i_scan.open_tc || i_scan.adc_full || i_scan.lin_exceed)) begin
            esr_set[`ABO_ESR_RANGE] = do_wr;
            if (i_scan.ch_temp) begin
                e.value = i_scan.value[31] ? -`ABO_SENT_TEMP : `ABO_SENT_TEMP;
            end else begin
                e.value = i_scan.value[31] ? -`ABO_SENT_VOLT : `ABO_SENT_VOLT;
            end
        end
        // look ahead for the next block start and the trigger point
        for (int i = 1; i < DEPTH; i++) begin
            idx = q.rd + AW'(i);
            if (!found_b && q.mem[idx].first) begin
                found_b = 1'b1;
                bidx = idx;
            end
            if (!found_t && q.mem[idx].trig) begin
                found_t = 1'b1;
                tidx = idx;
            end
        end
        if (do_wr && q.cnt == (AW+1)'(DEPTH)) begin
            // overrun: the pop of a coinciding read is absorbed by the discard
            if (q.nblk > (AW+1)'(1) && found_b) begin
                new_rd = bidx;
                d.nblk = q.nblk - (AW+1)'(1);
            end else if (q.nblk == (AW+1)'(1) && !q.mem[q.rd].trig && found_t) begin
                new_rd = tidx;
            end else begin
                new_rd = q.rd + AW'(1);
            end
            drop = new_rd - q.rd;
            d.mem[new_rd].first = 1'b1;
            d.rd = new_rd;
            d.cnt = q.cnt - {1'b0, drop};
            d.ovr = 1'b1;
            if (i_rd_req) begin
                d.rd_data = q.mem[q.rd];
                d.rd_valid = 1'b1;
            end
        end else if (i_rd_req && q.cnt != '0) begin
            d.rd_data = q.mem[q.rd];
            d.rd_valid = 1'b1;
            d.rd = q.rd + AW'(1);
            d.cnt = q.cnt - (AW+1)'(1);
            if (q.cnt == (AW+1)'(1)) begin
                d.nblk = '0;
            end else if (q.mem[d.rd].first) begin
                d.nblk = q.nblk - (AW+1)'(1);
            end else begin
                d.mem[d.rd].first = 1'b1;
            end
        end
        if (do_wr) begin
            // oldest stored entry always carries the block start mark
            e.first = q.first_pend || (d.cnt == '0);
            d.mem[q.wr] = e;
            d.wr = q.wr + AW'(1);
            d.cnt = d.cnt + (AW+1)'(1);
            d.first_pend = 1'b0;
            d.trig_pend = 1'b0;
            if (e.first) begin
                d.nblk = d.nblk + (AW+1)'(1);
            end
        end
        if (d.cnt == '0) begin
            d.ovr = 1'b0;
        end
        if (i_acq_end) begin
            d.acq = abo_pkg::ACQ_IDLE;
            d.lat_busy = 1'b0;
        end
        if (i_acq_arm) begin
            d.acq = abo_pkg::ACQ_PRE;
            d.first_pend = 1'b1;
            d.trig_pend = 1'b0;
            d.start_seen = 1'b0;
            d.stop_seen = 1'b0;
            d.lat_busy = 1'b0;
        end
        if (i_buf_reset) begin
            d.rd = '0;
            d.wr = '0;
            d.cnt = '0;
            d.nblk = '0;
            d.ovr = 1'b0;
            d.first_pend = (d.acq != abo_pkg::ACQ_IDLE);
            for (int i = 0; i < DEPTH; i++) begin
                d.mem[i].first = 1'b0;
                d.mem[i].trig = 1'b0;
            end
        end

        // queries; a flag raised in the clearing cycle survives
        if (i_err_query) begin
            d.err_reply = q.esr;
            d.err_rv = 1'b1;
        end
        d.esr = (i_err_query ? 8'h00 : q.esr) | esr_set;
        if (i_status_byte_query_cmd) begin
            d.stb_reply = stb_now;
            d.stb_rv = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_rd_valid = q.rd_valid;
    assign o_rd_data = q.rd_data;
    assign o_err_reply_valid = q.err_rv;
    assign o_err_reply = q.err_reply;
    assign o_stb_reply_valid = q.stb_rv;
    assign o_stb_reply = q.stb_reply;
    assign o_status_summary_byte = stb_now;
    assign o_error_source_reg = q.esr;
    assign o_overrun_status_bit = q.ovr;
    assign o_scan_count = q.cnt;
    assign o_rtc_now_ms = q.rtc;
endmodule

// File: core/abo_consts.svh
// constants for the acquisition buffer overrun control block
`ifndef ABO_CONSTS_SVH
`define ABO_CONSTS_SVH

`define ABO_CLK_NS 50
`define ABO_RTC_RES_MS 1
`define ABO_NS_PER_MS 1000000
`define ABO_TRIG_LAT_CUS 61095
`define ABO_NS_PER_CUS 10

`define ABO_SENT_TEMP 32'h0004fff6
`define ABO_SENT_VOLT 32'h036ff970

`define ABO_ESR_TRIG_OVR 0
`define ABO_ESR_RANGE 1
`define ABO_STB_SCAN_AVAIL 3
`define ABO_STB_OVERRUN 7

`endif

// File: core/abo_pkg.sv
// types shared by the acquisition buffer overrun control block
package abo_pkg;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_PRE,
        ACQ_POST
    } abo_acq_e;

    typedef struct packed {
        logic [31:0] value;
        logic [31:0] ts_ms;
        logic trig;
        logic first;
    } abo_entry_s;

    typedef struct packed {
        logic [31:0] value;
        logic ch_active;
        logic ch_temp;
        logic open_tc;
        logic adc_full;
        logic lin_exceed;
    } abo_scan_s;

endpackage

// File: tb/abo_checker.sv
// port assertions for the acquisition buffer
`timescale 1ns/100ps
module abo_checker #(
    parameter int DEPTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_buf_reset,
    input wire logic i_rd_req,
    input wire logic i_err_query,
    input wire logic i_status_byte_query_cmd,
    input wire logic o_rd_valid,
    input wire logic o_err_reply_valid,
    input wire logic [7:0] o_err_reply,
    input wire logic o_stb_reply_valid,
    input wire logic [7:0] o_stb_reply,
    input wire logic [7:0] o_status_summary_byte,
    input wire logic [7:0] o_error_source_reg,
    input wire logic o_overrun_status_bit,
    input wire logic [$clog2(DEPTH):0] o_scan_count
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    rd_empty_a: assert property (i_rd_req && o_scan_count == 0 |=> !o_rd_valid)
        else $error("read answered on empty buffer");
    rd_answer_a: assert property (i_rd_req && o_scan_count != 0 && !i_buf_reset |=> o_rd_valid)
        else $error("read not answered");
    err_reply_a: assert property (i_err_query |=> o_err_reply_valid && o_err_reply == $past(o_error_source_reg))
        else $error("error source reply wrong");
    stb_reply_a: assert property (i_status_byte_query_cmd |=> o_stb_reply_valid && o_stb_reply == $past(o_status_summary_byte))
        else $error("status byte reply wrong");
    stb_map_a: assert property (o_status_summary_byte == {o_overrun_status_bit, 3'h0, o_scan_count != 0, 3'h0})
        else $error("status byte bits wrong");
    // a pop from above one can never empty the buffer, so the bit must stay
    ovr_hold_a: assert property (o_overrun_status_bit && !i_buf_reset && o_scan_count > 1 |=> o_overrun_status_bit)
        else $error("overrun bit dropped early");
    bufrst_a: assert property (i_buf_reset |=> o_scan_count == 0 && !o_overrun_status_bit)
        else $error("buffer reset incomplete");
    ovr_set_a: assert property ($rose(o_overrun_status_bit) |-> $past(o_scan_count) == DEPTH)
        else $error("overrun bit set without full buffer");
    cover property ($rose(o_overrun_status_bit));
    cover property (o_rd_valid);
    cover property (o_err_reply_valid && o_err_reply[0]);
endmodule

// File: tb/abo_reader.sv
// controlling computer model: pops scans on request
`timescale 1ns/100ps
module abo_reader (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_rd_valid,
    input wire logic i_ovr,
    input wire logic i_empty,
    output logic o_rd_req,
    output logic o_corrupt
);
    always_ff @(posedge i_mclk) begin
        o_rd_req <= i_go && !i_rst;
        // data after an overrun is untrusted until the buffer drains or resets
        if (i_rst || i_empty) begin
            o_corrupt <= 1'b0;
        end else if (i_ovr && i_rd_valid) begin
            o_corrupt <= 1'b1;
        end
    end
endmodule

// File: tb/tb_abo_buffer.sv
// testbench for the acquisition buffer overrun control block
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module tb_abo_buffer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [10:0] cmd = '0;
    logic sc_v = 1'b0;
    abo_pkg::abo_scan_s sc = '0;
    logic [31:0] rtc_ms = 32'h64;
    logic rd_req, rd_valid, err_v, stb_v, ovr, corrupt;
    abo_pkg::abo_entry_s rd_data;
    logic [7:0] err_r, stb_r, stb_sum, esr;
    logic [2:0] cnt;
    logic [31:0] now_ms;
    int n_fail = 0;
    int checks = 0;
    // value, flags {active, temp, open, full, lin}, expected stored value
    logic [68:0] rows [5] = '{
        {32'h64, 5'h1c, 32'h0004fff6}, {32'h80000005, 5'h1a, 32'hfffb000a}, {32'h7, 5'h11, 32'h036ff970},
        {32'h9, 5'h0c, 32'h9}, {32'h11, 5'h10, 32'h11}};
    always #25 clk = ~clk;
    abo_buffer #(.DEPTH(4), .MS_CYCLES(10), .TRIG_LAT_CYCLES(8)) abo_buffer_i (.i_mclk(clk), .i_rst(rst),
        .i_buf_reset(cmd[0]), .i_acq_arm(cmd[1]), .i_acq_end(cmd[2]), .i_ext_trig(cmd[9]), .i_trig_falling(cmd[10]),
        .i_soft_trig(cmd[3]), .i_trig_stop(cmd[4]), .i_scan_valid(sc_v), .i_scan(sc), .i_rd_req(rd_req),
        .i_err_query(cmd[5]), .i_status_byte_query_cmd(cmd[6]), .i_rtc_set(cmd[7]), .i_rtc_ms(rtc_ms),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_err_reply_valid(err_v), .o_err_reply(err_r),
        .o_stb_reply_valid(stb_v), .o_stb_reply(stb_r), .o_status_summary_byte(stb_sum),
        .o_error_source_reg(esr), .o_overrun_status_bit(ovr), .o_scan_count(cnt), .o_rtc_now_ms(now_ms));
    abo_reader abo_reader_i (.i_mclk(clk), .i_rst(rst), .i_go(cmd[8]), .i_rd_valid(rd_valid), .i_ovr(ovr),
        .i_empty(cnt == 3'h0), .o_rd_req(rd_req), .o_corrupt(corrupt));
    task automatic pc(input int b);
        @(posedge clk) cmd[b] <= 1'b1;
        @(posedge clk) cmd[b] <= 1'b0;
    endtask
    task automatic scan(input logic [31:0] v, input logic [4:0] f = 5'h10);
        @(posedge clk) sc <= {v, f};
        sc_v <= 1'b1;
        @(posedge clk) sc_v <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] e);
        pc(8);
        @(posedge clk);
        #1;
        `CHK("read valid", 1'b1, rd_valid)
        `CHK("read value", e, rd_data.value)
    endtask
    task automatic q(input int b, input logic [7:0] e);
        pc(b);
        #1;
        `CHK("reply", {1'b1, e}, (b == 5) ? {err_v, err_r} : {stb_v, stb_r})
    endtask
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset count", 3'h0, cnt)
        $display("test reset done");
        pc(1);
        for (int i = 0; i < 5; i++) begin
            pc(0);
            scan(rows[i][68:37], rows[i][36:32]);
            rd(rows[i][31:0]);
        end
        $display("test sentinels done");
        pc(3);
        pc(3);
        q(5, 8'h03);
        q(5, 8'h00);
        $display("test trigger overrun done");
        pc(0);
        for (int i = 1; i < 6; i++) scan(i);
        #1;
        `CHK("full count", 3'h4, cnt)
        `CHK("summary byte", 8'h88, stb_sum)
        q(6, 8'h88);
        for (int i = 2; i < 6; i++) rd(i);
        `CHK("overrun cleared", 1'b0, ovr)
        `CHK("corrupt mark", 1'b1, corrupt)
        @(posedge clk);
        #1;
        `CHK("corrupt clear", 1'b0, corrupt)
        $display("test single drop done");
        pc(2);
        pc(0);
        pc(1);
        scan(10);
        scan(11);
        pc(3);
        for (int i = 12; i < 15; i++) scan(i);
        rd(12);
        $display("test pre-trigger drop done");
        pc(2);
        pc(0);
        pc(1);
        pc(3);
        scan(20);
        scan(21);
        pc(2);
        pc(1);
        pc(3);
        for (int i = 30; i < 33; i++) scan(i);
        #1;
        `CHK("block count", 3'h3, cnt)
        rd(30);
        $display("test block drop done");
        // falling-edge mode; pin parked high while idle so no edge is seen on arming
        @(posedge clk) cmd[10:9] <= 2'b11;
        pc(2);
        pc(0);
        pc(1);
        @(posedge clk) cmd[9] <= 1'b0;
        repeat (2) @(posedge clk);
        @(posedge clk) cmd[9] <= 1'b1;
        @(posedge clk) cmd[9] <= 1'b0;
        repeat (2) @(posedge clk);
        q(5, 8'h01);
        `CHK("error source cleared", 8'h00, esr)
        scan(40);
        scan(41);
        rd(40);
        `CHK("early trigger mark", 1'b0, rd_data.trig)
        `CHK("block start mark", 1'b1, rd_data.first)
        rd(41);
        `CHK("trigger point mark", 1'b1, rd_data.trig)
        $display("test external trigger done");
        pc(7);
        #1;
        `CHK("clock set", 32'h64, now_ms)
        repeat (12) @(posedge clk);
        #1;
        `CHK("clock tick", 32'h65, now_ms)
        $display("test clock done");
        conclude();
    end
endmodule
bind abo_buffer abo_checker #(.DEPTH(DEPTH)) abo_checker_i (.*);
